// ===== sspc_regs.svh
// sspc_regs.svh: register offsets, field positions, reset values and timing
// for the stop/standby power controller.
// assumes: included by bare name; 32-bit word-aligned registers on apb.
`ifndef SSPC_REGS_SVH
`define SSPC_REGS_SVH

// register byte offsets
`define SSPC_CTRL_OFS 12'h000
`define SSPC_STAT_OFS 12'h004
`define SSPC_CFG_OFS 12'h008
`define SSPC_KEY_OFS 12'h00c
`define SSPC_MODE_OFS 12'h010

// power control register fields
`define SSPC_CTRL_LPSEL 0
`define SSPC_CTRL_SBSEL 1
`define SSPC_CTRL_WCLR 2
`define SSPC_CTRL_SCLR 3

// power status register fields
`define SSPC_STAT_WAKE 0
`define SSPC_STAT_STBY 1
`define SSPC_STAT_EWUP 8

// clock and debug configuration register fields
`define SSPC_CFG_RTCON 0
`define SSPC_CFG_LFINT 1
`define SSPC_CFG_LFEXT 2
`define SSPC_CFG_RTCSRC 3
`define SSPC_CFG_HFEXT 5
`define SSPC_CFG_CFDON 6
`define SSPC_CFG_DBGSTOP 8
`define SSPC_CFG_DBGSTBY 9

// rtc clock source encodings
`define SSPC_RTCSRC_LF_EXT 2'h1
`define SSPC_RTCSRC_LF_INT 2'h2

// watchdog start key, arbitrary value
`define SSPC_WDOG_KEY 16'hcccc

// reset value of every register
`define SSPC_REG_RESET 32'h0000_0000

// timing
`define SSPC_CLK_PERIOD_NS 50
`define SSPC_REG_START_NS 2000
`define SSPC_WCLR_DELAY 2

`endif

// ===== sspc_pkg.sv
// sspc_pkg.sv: types shared by the stop/standby power controller.
// assumes: nothing beyond a systemverilog compiler.
package sspc_pkg;

    // power sequencing states
    typedef enum logic [2:0] {
        SSPC_RUN,
        SSPC_ENTRY,
        SSPC_STOP,
        SSPC_WAKE,
        SSPC_STANDBY,
        SSPC_RESTART
    } sspc_state_t;

    // register selected by an apb address
    typedef enum logic [2:0] {
        SSPC_SEL_NONE,
        SSPC_SEL_CTRL,
        SSPC_SEL_STAT,
        SSPC_SEL_CFG,
        SSPC_SEL_KEY,
        SSPC_SEL_MODE
    } sspc_sel_t;

endpackage : sspc_pkg

// ===== sspc_power_ctrl.sv
// sspc_power_ctrl.sv: stop/standby power controller with apb registers.
// assumes: one 20 MHz clock; pins and foreign-domain inputs arrive raw;
// core, flash and bus hold-offs are on the same clock.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "sspc_regs.svh"

module sspc_power_ctrl #(
    parameter int WAKE_PINS = 3,
    parameter int ADDR_W = 12
) (
    // clock, resets, enable
    input wire logic clock,
    input wire logic rst,
    input wire logic porRst,
    input wire logic clockEnable,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core sleep signalling
    input wire logic sleepReq,
    input wire logic deepSleepSelect,
    // entry hold-offs
    input wire logic flashBusy,
    input wire logic apbBusy,
    // stop wake and kernel clocks
    input wire logic wakeEvent,
    input wire logic kernelClkReq,
    // raw pins and foreign-domain inputs
    input wire logic [WAKE_PINS-1:0] wakePin,
    input wire logic rtcAlarm,
    input wire logic resetPinN,
    input wire logic watchdogExpired,
    input wire logic regulatorReady,
    // straps and pad configuration
    input wire logic watchdogHwStart,
    input wire logic tamperActive,
    // power and clock controls
    output logic coreClkOn,
    output logic hfClocksOn,
    output logic regulatorOn,
    output logic regulatorLowPower,
    output logic sysClkExternal,
    output logic clockFailDetectOn,
    // pads and debug
    output logic ioHold,
    output logic padHighZ,
    output logic [WAKE_PINS-1:0] wakePinInput,
    output logic tamperPadKeep,
    output logic debugAlive,
    // always-on domain
    output logic rtcClockOn,
    output logic internalLfOscOn,
    output logic externalLfOscOn,
    output logic [1:0] rtcClockSourceSel,
    output logic watchdogRunning,
    output logic systemResetReq
);

    // elaboration checks
    if (WAKE_PINS < 1 || WAKE_PINS > 8) begin : gBadPins
        $error("WAKE_PINS must be 1 to 8");
    end
    if (ADDR_W < 5) begin : gBadAddr
        $error("ADDR_W must be at least 5");
    end

    // synchroniser lane indices
    localparam int SW = WAKE_PINS + 4;
    localparam int IDX_RTC = WAKE_PINS;
    localparam int IDX_RSTP = WAKE_PINS + 1;
    localparam int IDX_WDOG = WAKE_PINS + 2;
    localparam int IDX_RRDY = WAKE_PINS + 3;

    // regulator startup delay in cycles, rounded up
    localparam int REG_CYC_RAW =
        (`SSPC_REG_START_NS + `SSPC_CLK_PERIOD_NS - 1) / `SSPC_CLK_PERIOD_NS;
    localparam int REG_CYC = (REG_CYC_RAW < 1) ? 1 : REG_CYC_RAW;
    localparam int CW = $clog2(REG_CYC + 1);
    localparam int CD = `SSPC_WCLR_DELAY;

    // whole state of the block
    typedef struct packed {
        sspc_pkg::sspc_state_t state;
        logic tgtStandby;
        logic lpUsed;
        logic lpSel;
        logic sbSel;
        logic [CD-1:0] wclrPipe;
        logic wakeFlag;
        logic standbyFlag;
        logic [WAKE_PINS-1:0] ewup;
        logic rtc_clock_enable;
        logic lfIntOn;
        logic lfExtOn;
        logic [1:0] rtc_clock_source_sel;
        logic hfExt;
        logic cfdOn;
        logic dbgStop;
        logic dbgStby;
        logic wdogRun;
        logic [CW-1:0] waitCnt;
        logic [SW-1:0] sync1;
        logic [SW-1:0] sync2;
        logic [SW-1:0] sync3;
        logic [SW-1:0] filt;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic coreClk;
        logic hfOn;
        logic regOn;
        logic regLp;
        logic ioHold;
        logic padHiZ;
        logic tamperKeep;
        logic dbgAlive;
        logic resetReq;
    } sspc_q_t;

    sspc_q_t q;
    sspc_q_t n;

    // address decode, shared by read and write paths
    function automatic sspc_pkg::sspc_sel_t decodeAddr(
        input logic [ADDR_W-1:0] a
    );
        sspc_pkg::sspc_sel_t s;
        s = sspc_pkg::SSPC_SEL_NONE;
        if (a == ADDR_W'(`SSPC_CTRL_OFS)) begin
            s = sspc_pkg::SSPC_SEL_CTRL;
        end else if (a == ADDR_W'(`SSPC_STAT_OFS)) begin
            s = sspc_pkg::SSPC_SEL_STAT;
        end else if (a == ADDR_W'(`SSPC_CFG_OFS)) begin
            s = sspc_pkg::SSPC_SEL_CFG;
        end else if (a == ADDR_W'(`SSPC_KEY_OFS)) begin
            s = sspc_pkg::SSPC_SEL_KEY;
        end else if (a == ADDR_W'(`SSPC_MODE_OFS)) begin
            s = sspc_pkg::SSPC_SEL_MODE;
        end
        return s;
    endfunction : decodeAddr

    // next-state logic for the whole block
    always_comb begin
        logic [SW-1:0] rawIn;
        logic [SW-1:0] newFilt;
        logic [SW-1:0] rise;
        logic pinWake;
        logic standbyWake;
        logic wrEn;
        logic [31:0] rd;
        sspc_pkg::sspc_sel_t sel;
        rawIn = {regulatorReady, watchdogExpired, resetPinN, rtcAlarm, wakePin};
        newFilt = q.filt;
        rise = '0;
        pinWake = 1'b0;
        standbyWake = 1'b0;
        wrEn = 1'b0;
        rd = `SSPC_REG_RESET;
        sel = decodeAddr(paddr);
        n = q;

        // three-stage pin synchronisers, accepted when stages 2 and 3 agree
        n.sync1 = rawIn;
        n.sync2 = q.sync1;
        n.sync3 = q.sync2;
        for (int i = 0; i < SW; i++) begin
            if (q.sync2[i] == q.sync3[i]) begin
                newFilt[i] = q.sync3[i];
            end
        end
        n.filt = newFilt;
        rise = newFilt & ~q.filt;

        // enabled wake pin rising edge; a pin already high when enabled is not caught
        pinWake = |(newFilt[WAKE_PINS-1:0] & q.ewup & ~(q.filt[WAKE_PINS-1:0] & q.ewup));

        // apb read mux
        case (sel)
            sspc_pkg::SSPC_SEL_CTRL: begin
                rd[`SSPC_CTRL_LPSEL] = q.lpSel;
                rd[`SSPC_CTRL_SBSEL] = q.sbSel; // clear bits read zero
            end
            sspc_pkg::SSPC_SEL_STAT: begin
                rd[`SSPC_STAT_WAKE] = q.wakeFlag;
                rd[`SSPC_STAT_STBY] = q.standbyFlag;
                rd[`SSPC_STAT_EWUP +: WAKE_PINS] = q.ewup;
            end
            sspc_pkg::SSPC_SEL_CFG: begin
                rd[`SSPC_CFG_RTCON] = q.rtc_clock_enable;
                rd[`SSPC_CFG_LFINT] = q.lfIntOn;
                rd[`SSPC_CFG_LFEXT] = q.lfExtOn;
                rd[`SSPC_CFG_RTCSRC +: 2] = q.rtc_clock_source_sel;
                rd[`SSPC_CFG_HFEXT] = q.hfExt;
                rd[`SSPC_CFG_CFDON] = q.cfdOn;
                rd[`SSPC_CFG_DBGSTOP] = q.dbgStop;
                rd[`SSPC_CFG_DBGSTBY] = q.dbgStby;
            end
            sspc_pkg::SSPC_SEL_KEY: begin
                rd[0] = q.wdogRun;
            end
            sspc_pkg::SSPC_SEL_MODE: begin
                rd = 32'(q.state);
            end
            default: begin
                rd = `SSPC_REG_RESET;
            end
        endcase

        // apb handshake: one wait state, answer registered
        if (psel && penable && !q.pready) begin
            n.pready = 1'b1;
            n.prdata = pwrite ? `SSPC_REG_RESET : rd;
            n.pslverr = (sel == sspc_pkg::SSPC_SEL_NONE);
        end else begin
            n.pready = 1'b0;
            n.pslverr = 1'b0;
        end
        wrEn = psel && penable && q.pready && pwrite;

        // clear-wake request travels the delay line
        n.wclrPipe = {q.wclrPipe[CD-2:0], 1'b0};

        // register writes
        if (wrEn) begin
            case (sel)
                sspc_pkg::SSPC_SEL_CTRL: begin
                    n.lpSel = pwdata[`SSPC_CTRL_LPSEL];
                    n.sbSel = pwdata[`SSPC_CTRL_SBSEL];
                    n.wclrPipe[0] = pwdata[`SSPC_CTRL_WCLR];
                    if (pwdata[`SSPC_CTRL_SCLR]) begin
                        n.standbyFlag = 1'b0;
                    end
                end
                sspc_pkg::SSPC_SEL_STAT: begin
                    n.ewup = pwdata[`SSPC_STAT_EWUP +: WAKE_PINS];
                end
                sspc_pkg::SSPC_SEL_CFG: begin
                    n.rtc_clock_enable = pwdata[`SSPC_CFG_RTCON];
                    n.lfIntOn = pwdata[`SSPC_CFG_LFINT];
                    n.lfExtOn = pwdata[`SSPC_CFG_LFEXT];
                    n.rtc_clock_source_sel = pwdata[`SSPC_CFG_RTCSRC +: 2];
                    n.hfExt = pwdata[`SSPC_CFG_HFEXT];
                    n.cfdOn = pwdata[`SSPC_CFG_CFDON];
                    n.dbgStop = pwdata[`SSPC_CFG_DBGSTOP];
                    n.dbgStby = pwdata[`SSPC_CFG_DBGSTBY];
                end
                sspc_pkg::SSPC_SEL_KEY: begin
                    if (pwdata[15:0] == `SSPC_WDOG_KEY) begin
                        n.wdogRun = 1'b1;
                    end
                end
                default: begin
                    n.wdogRun = n.wdogRun;
                end
            endcase
        end

        // watchdog hardware option; nothing but reset stops it
        if (watchdogHwStart) begin
            n.wdogRun = 1'b1;
        end

        // wake flag: clear two cycles after the write, set wins
        if (q.wclrPipe[CD-1]) begin
            n.wakeFlag = 1'b0;
        end
        if (pinWake || rise[IDX_RTC]) begin
            n.wakeFlag = 1'b1;
        end

        // power sequencer
        standbyWake = pinWake || rise[IDX_RTC] || !newFilt[IDX_RSTP] || newFilt[IDX_WDOG];
        n.resetReq = 1'b0;
        case (q.state)
            sspc_pkg::SSPC_RUN: begin
                if (sleepReq && deepSleepSelect) begin
                    n.state = sspc_pkg::SSPC_ENTRY;
                    n.tgtStandby = q.sbSel;
                end
            end
            sspc_pkg::SSPC_ENTRY: begin
                if (!flashBusy && !apbBusy) begin
                    n.lpUsed = 1'b0;
                    if (q.tgtStandby) begin
                        n.state = sspc_pkg::SSPC_STANDBY;
                    end else begin
                        n.state = sspc_pkg::SSPC_STOP;
                    end
                end
            end
            sspc_pkg::SSPC_STOP: begin
                if (q.regLp) begin
                    n.lpUsed = 1'b1;
                end
                if (wakeEvent) begin
                    n.hfExt = 1'b0;
                    n.waitCnt = '0;
                    if (q.lpUsed || q.regLp) begin
                        n.state = sspc_pkg::SSPC_WAKE;
                    end else begin
                        n.state = sspc_pkg::SSPC_RUN;
                    end
                end
            end
            sspc_pkg::SSPC_WAKE: begin
                if (q.waitCnt != CW'(REG_CYC)) begin
                    n.waitCnt = q.waitCnt + CW'(1);
                end else if (newFilt[IDX_RRDY]) begin
                    n.state = sspc_pkg::SSPC_RUN;
                end
            end
            sspc_pkg::SSPC_STANDBY: begin
                if (standbyWake) begin
                    n.state = sspc_pkg::SSPC_RESTART;
                    n.resetReq = 1'b1;
                    n.standbyFlag = 1'b1;
                end
            end
            sspc_pkg::SSPC_RESTART: begin
                // core-domain registers lose state; status survives
                n.state = sspc_pkg::SSPC_RUN;
                n.lpSel = 1'b0;
                n.sbSel = 1'b0;
                n.lfIntOn = 1'b0;
                n.hfExt = 1'b0;
                n.cfdOn = 1'b0;
                n.dbgStop = 1'b0;
                n.dbgStby = 1'b0;
                n.wclrPipe = '0;
            end
            default: begin
                n.state = sspc_pkg::SSPC_RUN;
            end
        endcase

        // power, clock and pad controls from the coming state
        n.coreClk = 1'b0;
        n.hfOn = 1'b0;
        n.regOn = 1'b1;
        n.regLp = 1'b0;
        n.ioHold = 1'b0;
        n.padHiZ = 1'b0;
        n.tamperKeep = 1'b0;
        n.dbgAlive = 1'b1;
        case (n.state)
            sspc_pkg::SSPC_STOP: begin
                n.regLp = n.lpSel && !kernelClkReq;
                n.ioHold = 1'b1;
                n.dbgAlive = n.dbgStop;
            end
            sspc_pkg::SSPC_WAKE: begin
                n.ioHold = 1'b1;
                n.dbgAlive = n.dbgStop;
            end
            sspc_pkg::SSPC_STANDBY: begin
                n.regOn = 1'b0;
                n.padHiZ = 1'b1;
                n.tamperKeep = tamperActive;
                n.dbgAlive = n.dbgStby;
            end
            sspc_pkg::SSPC_RESTART: begin
                n.regOn = 1'b1;
            end
            default: begin
                n.coreClk = 1'b1;
                n.hfOn = 1'b1;
            end
        endcase

        // resets: system reset keeps standby flag, por clears it
        if (rst || porRst) begin
            n = '0;
            n.state = sspc_pkg::SSPC_RUN;
            n.sync1[IDX_RSTP] = 1'b1;
            n.sync2[IDX_RSTP] = 1'b1;
            n.sync3[IDX_RSTP] = 1'b1;
            n.filt[IDX_RSTP] = 1'b1;
            n.coreClk = 1'b1;
            n.hfOn = 1'b1;
            n.regOn = 1'b1;
            n.dbgAlive = 1'b1;
            if (!porRst) begin
                n.standbyFlag = q.standbyFlag;
            end
        end
    end

    // single state register, frozen while the clock enable is low and no reset is asserted
    always_ff @(posedge clock) begin
        if (rst || porRst || clockEnable) begin
            q <= n;
        end
    end

    // outputs straight from flip-flops
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign coreClkOn = q.coreClk;
    assign hfClocksOn = q.hfOn;
    assign regulatorOn = q.regOn;
    assign regulatorLowPower = q.regLp;
    assign sysClkExternal = q.hfExt;
    assign clockFailDetectOn = q.cfdOn;
    assign ioHold = q.ioHold;
    assign padHighZ = q.padHiZ;
    assign wakePinInput = q.ewup;
    assign tamperPadKeep = q.tamperKeep;
    assign debugAlive = q.dbgAlive;
    assign rtcClockOn = q.rtc_clock_enable;
    assign internalLfOscOn = q.lfIntOn;
    assign externalLfOscOn = q.lfExtOn;
    assign rtcClockSourceSel = q.rtc_clock_source_sel;
    assign watchdogRunning = q.wdogRun;
    assign systemResetReq = q.resetReq;

endmodule : sspc_power_ctrl

// ===== sspc_power_ctrl_asserts.sv
// sspc_power_ctrl_asserts.sv: port-level checks of the stop/standby power controller.
// assumes: bound to sspc_power_ctrl; one clock, synchronous active-high resets.
`timescale 1ns/1ps
module sspc_power_ctrl_asserts (
    // clock and resets
    input wire logic clock,
    input wire logic rst,
    input wire logic porRst,
    input wire logic clockEnable,
    // apb handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // sleep signalling and hold-offs
    input wire logic sleepReq,
    input wire logic deepSleepSelect,
    input wire logic flashBusy,
    input wire logic apbBusy,
    input wire logic kernelClkReq,
    // power and pad outputs
    input wire logic coreClkOn,
    input wire logic hfClocksOn,
    input wire logic regulatorOn,
    input wire logic regulatorLowPower,
    input wire logic sysClkExternal,
    input wire logic ioHold,
    input wire logic padHighZ,
    input wire logic tamperPadKeep,
    input wire logic watchdogRunning,
    input wire logic systemResetReq
);
    // single domain, either reset disables
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst || porRst);

    // deep sleep request gates the core clock once no hold-off stands
    stop_entry_a: assert property (sleepReq && deepSleepSelect && coreClkOn && clockEnable ##1
        (!flashBusy && !apbBusy && clockEnable)[*2] |-> ##[0:1] !coreClkOn)
        else $error("sleep request did not gate the core clock");
    busy_hold_a: assert property ((flashBusy || apbBusy) && coreClkOn |=> coreClkOn)
        else $error("core clock gated under a hold-off");
    stop_clocks_a: assert property (ioHold |-> !coreClkOn && !hfClocksOn && !padHighZ && regulatorOn)
        else $error("stop state with clocks or pads wrong");
    reg_lowpower_a: assert property (regulatorLowPower |-> ioHold && !$past(kernelClkReq))
        else $error("low-power regulator at the wrong time");
    standby_power_a: assert property (!regulatorOn || padHighZ |->
        padHighZ && !regulatorOn && !hfClocksOn && !coreClkOn)
        else $error("standby power state inconsistent");
    tamper_pad_a: assert property (tamperPadKeep |-> padHighZ)
        else $error("tamper pad kept outside standby");
    wdog_sticky_a: assert property (watchdogRunning |=> watchdogRunning)
        else $error("watchdog stopped without reset");
    restart_pulse_a: assert property (systemResetReq |-> $past(padHighZ) && !coreClkOn ##1 !systemResetReq)
        else $error("restart pulse not one cycle after standby");
    stop_exit_a: assert property ($fell(ioHold) |-> coreClkOn && !sysClkExternal)
        else $error("stop exit without internal clock selected");
    apb_wait_a: assert property (psel && penable && !pready && clockEnable |=> pready)
        else $error("apb answer not after one wait state");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("apb error without ready");

    // main scenarios reached
    cover property (ioHold && regulatorLowPower);
    cover property (padHighZ && tamperPadKeep);
    cover property (systemResetReq);
    cover property (pslverr);
endmodule : sspc_power_ctrl_asserts

// ===== sspc_core_model.sv
// sspc_core_model.sv: model of the core's sleep signalling and of the regulator.
// assumes: same clock as the controller; bench commands arrive by nba.
`timescale 1ns/1ps
module sspc_core_model (
    // clock
    input wire logic clock,
    // bench commands
    input wire logic doSleep,
    input wire logic slowReg,
    // controller side
    input wire logic regulatorLowPower,
    output logic sleepReq,
    output logic regulatorReady
);
    int cnt;

    // power-up state
    initial begin
        sleepReq = 1'b0;
        regulatorReady = 1'b1;
        cnt = 0;
    end

    // one pulse per command, as a wait instruction gives
    always @(posedge clock) begin
        sleepReq <= doSleep && !sleepReq;
    end

    // ready drops in low power and returns late, slowly if asked
    always @(posedge clock) begin
        if (regulatorLowPower) begin
            cnt <= slowReg ? 60 : 3;
            regulatorReady <= 1'b0;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else begin
            regulatorReady <= 1'b1;
        end
    end
endmodule : sspc_core_model

// ===== sspc_power_ctrl_tb.sv
// sspc_power_ctrl_tb.sv: self-checking bench of the stop/standby power controller.
// assumes: core and regulator model in sspc_core_model; the bench is the apb master.
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin nMismatch++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, a, b); end end
module sspc_power_ctrl_tb;
    logic clock, rst, porRst, clockEnable, psel, penable, pwrite, pready, pslverr, err, lpSel;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, cfg;
    logic sleepReq, deepSleepSelect, flashBusy, apbBusy, wakeEvent, kernelClkReq, doSleep, slowReg;
    logic [2:0] wakePin, wakePinInput, ewup;
    logic rtcAlarm, resetPinN, watchdogExpired, regulatorReady, watchdogHwStart, tamperActive;
    logic coreClkOn, hfClocksOn, regulatorOn, regulatorLowPower, sysClkExternal, clockFailDetectOn;
    logic ioHold, padHighZ, tamperPadKeep, debugAlive, rtcClockOn, internalLfOscOn, externalLfOscOn;
    logic watchdogRunning, systemResetReq;
    logic [1:0] rtcClockSourceSel;
    int cyc, n, nTests, nMismatch;

    sspc_power_ctrl i_sspc_power_ctrl (.clock, .rst, .porRst, .clockEnable, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .sleepReq, .deepSleepSelect, .flashBusy, .apbBusy,
        .wakeEvent, .kernelClkReq, .wakePin, .rtcAlarm, .resetPinN, .watchdogExpired, .regulatorReady,
        .watchdogHwStart, .tamperActive, .coreClkOn, .hfClocksOn, .regulatorOn, .regulatorLowPower,
        .sysClkExternal, .clockFailDetectOn, .ioHold, .padHighZ, .wakePinInput, .tamperPadKeep,
        .debugAlive, .rtcClockOn, .internalLfOscOn, .externalLfOscOn, .rtcClockSourceSel,
        .watchdogRunning, .systemResetReq);
    sspc_core_model i_sspc_core_model (.clock, .doSleep, .slowReg, .regulatorLowPower, .sleepReq,
        .regulatorReady);

    // expected values
    function automatic logic [31:0] expStat(input logic [2:0] en, input logic sb, input logic wu);
        return {21'h0, en, 6'h0, sb, wu};
    endfunction : expStat
    function automatic logic expLp(input logic lp, input logic kr);
        return lp && !kr;
    endfunction : expLp

    // one apb transfer, waits for ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb
    // core executes a wait instruction
    task automatic goSleep;
        doSleep <= 1'b1;
        @(posedge clock);
        doSleep <= 1'b0;
        @(posedge clock);
    endtask : goSleep
    // wait for the core clock level, counting cycles
    task automatic waitClk(input logic v);
        n = 0;
        while (coreClkOn !== v) begin
            @(posedge clock);
            n++;
        end
    endtask : waitClk
    // verdict and end of run
    task automatic summarize;
        $display("tests %0d mismatches %0d", nTests, nMismatch);
        if (nMismatch == 0 && nTests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    // clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // cycle ceiling
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            nMismatch++;
            summarize();
        end
    end

    // main sequence
    initial begin
        {rst, porRst, clockEnable, psel, penable, pwrite, paddr, pwdata} = {3'b111, 47'h0};
        {deepSleepSelect, flashBusy, apbBusy, wakeEvent, kernelClkReq, wakePin, rtcAlarm} = '0;
        {resetPinN, watchdogExpired, watchdogHwStart, tamperActive, doSleep, slowReg} = 6'h20;
        void'($urandom(94));
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        porRst <= 1'b0;
        @(posedge clock);
        `CHK({coreClkOn, hfClocksOn, regulatorOn, debugAlive, ioHold, padHighZ}, 6'h3c)
        for (int a = 0; a < 24; a += 4) begin
            apb(1'b0, 12'(a), 32'h0);
            `CHK({err, rd}, {a == 20, 32'h0})
        end
        $display("test reset done");
        apb(1'b1, 12'h000, 32'hf);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h3)
        cfg = ($urandom & 32'h367) | (32'($urandom % 2 + 1) << 3);
        cfg[6] = cfg[6] | cfg[5];
        apb(1'b1, 12'h008, cfg);
        apb(1'b0, 12'h008, 32'h0);
        `CHK(rd, cfg)
        `CHK({clockFailDetectOn, sysClkExternal, rtcClockSourceSel, externalLfOscOn, internalLfOscOn,
            rtcClockOn}, cfg[6:0])
        $display("test registers done");
        // deep sleep select low leaves the core running
        goSleep();
        repeat (6) @(posedge clock);
        `CHK(coreClkOn, 1'b1)
        deepSleepSelect <= 1'b1;
        // stop with hold-offs, regulator choices and wake delay
        for (int i = 0; i < 3; i++) begin
            lpSel = i > 0;
            kernelClkReq <= i == 2;
            slowReg <= 1'($urandom);
            apb(1'b1, 12'h000, {31'h0, lpSel});
            apb(1'b1, 12'h008, cfg | 32'h60);
            flashBusy <= i == 1;
            apbBusy <= i == 2;
            goSleep();
            repeat (6) @(posedge clock);
            `CHK(coreClkOn, i > 0)
            flashBusy <= 1'b0;
            apbBusy <= 1'b0;
            waitClk(1'b0);
            apb(1'b0, 12'h010, 32'h0);
            `CHK({rd, hfClocksOn, ioHold, padHighZ, debugAlive}, {32'h2, 3'b010, cfg[8]})
            `CHK(regulatorLowPower, expLp(lpSel, i == 2))
            wakeEvent <= 1'b1;
            @(posedge clock);
            wakeEvent <= 1'b0;
            waitClk(1'b1);
            `CHK({n > 38, sysClkExternal}, {expLp(lpSel, i == 2), 1'b0})
        end
        $display("test stop done");
        kernelClkReq <= 1'b0;
        ewup = 3'($urandom) | 3'h1;
        apb(1'b1, 12'h00c, 32'hcccc);
        // standby and each wake source
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, 12'h004, {21'h0, ewup, 8'h0});
            apb(1'b1, 12'h000, 32'h4);
            apb(1'b0, 12'h004, 32'h0);
            `CHK(rd[0], 1'b0)
            apb(1'b1, 12'h000, 32'h2);
            apb(1'b1, 12'h008, cfg);
            tamperActive <= 1'($urandom);
            goSleep();
            while (padHighZ !== 1'b1) @(posedge clock);
            @(posedge clock);
            `CHK({regulatorOn, hfClocksOn, coreClkOn, ioHold, wakePinInput, debugAlive, tamperPadKeep},
                {4'h0, ewup, cfg[9], tamperActive})
            `CHK(watchdogRunning, 1'b1)
            case (s)
                0: wakePin[0] <= 1'b1;
                1: rtcAlarm <= 1'b1;
                2: resetPinN <= 1'b0;
                default: watchdogExpired <= 1'b1;
            endcase
            while (systemResetReq !== 1'b1) @(posedge clock);
            {wakePin, rtcAlarm, resetPinN, watchdogExpired} <= 6'h2;
            repeat (6) @(posedge clock);
            apb(1'b0, 12'h000, 32'h0);
            `CHK(rd, 32'h0)
            apb(1'b0, 12'h004, 32'h0);
            `CHK(rd, expStat(ewup, 1'b1, s < 2))
            apb(1'b0, 12'h008, 32'h0);
            `CHK(rd, cfg & 32'h1d)
        end
        $display("test standby done");
        // system reset keeps the standby flag, the clear request drops it
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        `CHK(watchdogRunning, 1'b0)
        apb(1'b0, 12'h004, 32'h0);
        `CHK(rd, expStat(3'h0, 1'b1, 1'b0))
        watchdogHwStart <= 1'b1;
        apb(1'b1, 12'h000, 32'h8);
        apb(1'b0, 12'h004, 32'h0);
        `CHK({rd, watchdogRunning}, {32'h0, 1'b1})
        $display("test system reset done");
        summarize();
    end
endmodule : sspc_power_ctrl_tb

bind sspc_power_ctrl sspc_power_ctrl_asserts i_sspc_power_ctrl_asserts (.clock, .rst, .porRst, .clockEnable,
    .psel, .penable, .pready, .pslverr, .sleepReq, .deepSleepSelect, .flashBusy, .apbBusy, .kernelClkReq,
    .coreClkOn, .hfClocksOn, .regulatorOn, .regulatorLowPower, .sysClkExternal, .ioHold, .padHighZ,
    .tamperPadKeep, .watchdogRunning, .systemResetReq);
